// [ccx_core.sv]
// Contract
// - Push return address before loading counter
// - Call opcode loads eleven literal bits
// - Counter 12:11 from high latch 4:3
// - Call takes two cycles, flags untouched
// - Clear accumulator to zero, set zero
// - Watchdog clear resets counter and prescaler
// - Watchdog clear sets timeout and power-down
// - Complement file to accumulator or file
//
// The Wishbone interface to the registers and the address map were decided locally.
module ccx_core (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [ccx_pkg::INSTR_W-1:0] instr,
   input wire logic instr_valid,
   output logic instr_ready,
   output logic stack_push,
   output logic [ccx_pkg::PC_W-1:0] stack_top,
   output logic [ccx_pkg::PC_W-1:0] program_counter,
   output logic watchdog_clear,
   output logic prescaler_clear,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);

   // ****************************************************************
   // Decode helpers
   // ****************************************************************
   function automatic logic is_call(input logic [ccx_pkg::INSTR_W-1:0] w);
      return w[ccx_pkg::CALL_OPC_HI:ccx_pkg::CALL_OPC_LO] == ccx_pkg::CALL_OPC
         && !w[ccx_pkg::CALL_SEL_BIT];
   endfunction

   function automatic logic is_compf(input logic [ccx_pkg::INSTR_W-1:0] w);
      return w[ccx_pkg::INSTR_W-1:ccx_pkg::COMPF_OPC_LO] == ccx_pkg::COMPF_OPC;
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   ccx_pkg::ccx_state_e state, next_state;
   logic [ccx_pkg::INSTR_W-1:0] ir, next_ir;
   logic [7:0] accumulator, next_accumulator;
   logic [4:0] pc_high_latch, next_pc_high_latch;
   logic zero_flag, next_zero_flag;
   logic timeout_flag, next_timeout_flag;
   logic power_down_flag, next_power_down_flag;
   logic [ccx_pkg::PC_W-1:0] next_program_counter, next_stack_top;
   logic next_stack_push, next_watchdog_clear, next_prescaler_clear, next_instr_ready;
   logic [31:0] next_wb_dat_o;
   logic next_wb_ack_o;
   logic file_we;
   logic [7:0] file_rdata, comp_result;
   logic bus_req, bus_wr;

   // ****************************************************************
   // File register store
   // ****************************************************************
   ccx_file_mem u_file (
      .mclk(mclk),
      .we(file_we),
      .waddr(ir[ccx_pkg::FADDR_W-1:0]),
      .wdata(comp_result),
      .raddr(instr[ccx_pkg::FADDR_W-1:0]),
      .rdata(file_rdata)
   );

   // Inverted file word, write-back strobe and bus request qualifiers
   assign comp_result = ~file_rdata;
   assign file_we = (state == ccx_pkg::ST_EXEC) && is_compf(ir)
      && ir[ccx_pkg::DEST_BIT];
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];

   // ****************************************************************
   // Sequencer and execution
   // ****************************************************************
   // An instruction beats a bus write to the same field in one cycle
   always_comb begin
      next_state = state;
      next_ir = ir;
      next_accumulator = accumulator;
      next_pc_high_latch = pc_high_latch;
      next_zero_flag = zero_flag;
      next_timeout_flag = timeout_flag;
      next_power_down_flag = power_down_flag;
      next_program_counter = program_counter;
      next_stack_top = stack_top;
      next_stack_push = 1'b0;
      next_watchdog_clear = 1'b0;
      next_prescaler_clear = 1'b0;
      next_instr_ready = instr_ready;
      // Software writes first, so execution below overrides them
      if (bus_wr && wb_adr_i == ccx_pkg::ACC_OFF) begin
         next_accumulator = wb_dat_i[7:0];
      end else if (bus_wr && wb_adr_i == ccx_pkg::STATUS_OFF) begin
         next_zero_flag = wb_dat_i[ccx_pkg::ST_ZERO];
         next_timeout_flag = wb_dat_i[ccx_pkg::ST_TMOUT];
         next_power_down_flag = wb_dat_i[ccx_pkg::ST_PWRDN];
      end else if (bus_wr && wb_adr_i == ccx_pkg::LATCH_OFF) begin
         next_pc_high_latch = wb_dat_i[ccx_pkg::LATCH_W-1:0];
      end
      // Idle takes a word, execute finishes it, a call holds one cycle more
      case (state)
         ccx_pkg::ST_IDLE: begin
            if (instr_valid) begin
               next_ir = instr;
               next_instr_ready = 1'b0;
               next_state = ccx_pkg::ST_EXEC;
               if (is_call(instr)) begin
                  // Push goes out one edge before the counter moves
                  next_stack_push = 1'b1;
                  next_stack_top = program_counter + 13'h0001;
               end
            end
         end
         ccx_pkg::ST_EXEC: begin
            next_state = ccx_pkg::ST_IDLE;
            next_instr_ready = 1'b1;
            next_program_counter = program_counter + 13'h0001;
            if (is_call(ir)) begin
               next_program_counter = {pc_high_latch[ccx_pkg::LATCH_HI:ccx_pkg::LATCH_LO],
                  ir[ccx_pkg::CALL_LIT_HI:ccx_pkg::CALL_LIT_LO]};
               next_state = ccx_pkg::ST_CALL2;
               next_instr_ready = 1'b0;
            end else if (ir[ccx_pkg::INSTR_W-1:ccx_pkg::CLRACC_OPC_LO]
                  == ccx_pkg::CLRACC_OPC) begin
               next_accumulator = 8'h00;
               next_zero_flag = 1'b1;
            end else if (ir == ccx_pkg::WDOG_CLR_WORD) begin
               next_watchdog_clear = 1'b1;
               next_prescaler_clear = 1'b1;
               next_timeout_flag = 1'b1;
               next_power_down_flag = 1'b1;
            end else if (is_compf(ir)) begin
               if (!ir[ccx_pkg::DEST_BIT]) begin
                  next_accumulator = comp_result;
               end
               next_zero_flag = (comp_result == 8'h00);
            end
         end
         ccx_pkg::ST_CALL2: begin
            // Second cycle of a call; flags are left alone
            next_state = ccx_pkg::ST_IDLE;
            next_instr_ready = 1'b1;
         end
         default: begin
            next_state = ccx_pkg::ST_IDLE;
            next_instr_ready = 1'b1;
         end
      endcase
   end

   // ****************************************************************
   // Bus read path
   // ****************************************************************
   // Bus reads answer one cycle after the request; unmapped reads give zero
   always_comb begin
      next_wb_ack_o = bus_req;
      next_wb_dat_o = 32'h0000_0000;
      if (bus_req && !wb_we_i) begin
         if (wb_adr_i == ccx_pkg::ACC_OFF) begin
            next_wb_dat_o = {24'h00_0000, accumulator};
         end else if (wb_adr_i == ccx_pkg::STATUS_OFF) begin
            next_wb_dat_o[ccx_pkg::ST_ZERO] = zero_flag;
            next_wb_dat_o[ccx_pkg::ST_TMOUT] = timeout_flag;
            next_wb_dat_o[ccx_pkg::ST_PWRDN] = power_down_flag;
         end else if (wb_adr_i == ccx_pkg::LATCH_OFF) begin
            next_wb_dat_o = {27'h000_0000, pc_high_latch};
         end else if (wb_adr_i == ccx_pkg::PC_OFF) begin
            next_wb_dat_o = {19'h0_0000, program_counter};
         end
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   // Synchronous reset; every output leaves straight from a flop
   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= ccx_pkg::ST_IDLE;
         ir <= 14'h0000;
         accumulator <= ccx_pkg::ACC_RST;
         pc_high_latch <= ccx_pkg::LATCH_RST;
         zero_flag <= ccx_pkg::ZERO_RST;
         timeout_flag <= ccx_pkg::TMOUT_RST;
         power_down_flag <= ccx_pkg::PWRDN_RST;
         program_counter <= ccx_pkg::PC_RST;
         stack_top <= ccx_pkg::PC_RST;
         stack_push <= 1'b0;
         watchdog_clear <= 1'b0;
         prescaler_clear <= 1'b0;
         instr_ready <= 1'b1;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         state <= next_state;
         ir <= next_ir;
         accumulator <= next_accumulator;
         pc_high_latch <= next_pc_high_latch;
         zero_flag <= next_zero_flag;
         timeout_flag <= next_timeout_flag;
         power_down_flag <= next_power_down_flag;
         program_counter <= next_program_counter;
         stack_top <= next_stack_top;
         stack_push <= next_stack_push;
         watchdog_clear <= next_watchdog_clear;
         prescaler_clear <= next_prescaler_clear;
         instr_ready <= next_instr_ready;
         wb_ack_o <= next_wb_ack_o;
         wb_dat_o <= next_wb_dat_o;
      end
   end

endmodule

// [ccx_pkg.sv]
package ccx_pkg;

   // ****************************************************************
   // Instruction word layout
   // ****************************************************************
   localparam int INSTR_W = 14;
   localparam int PC_W = 13;
   localparam logic [1:0] CALL_OPC = 2'h2;           // Bits 13:12 of a call
   localparam int CALL_OPC_HI = 13;
   localparam int CALL_OPC_LO = 12;
   localparam int CALL_SEL_BIT = 11;                 // Zero for call, one for goto
   localparam int CALL_LIT_HI = 10;
   localparam int CALL_LIT_LO = 0;
   localparam logic [6:0] CLRACC_OPC = 7'h02;        // Bits 13:7 of clear accumulator
   localparam int CLRACC_OPC_LO = 7;
   localparam logic [13:0] WDOG_CLR_WORD = 14'h0064; // Whole word of clear watchdog
   localparam logic [5:0] COMPF_OPC = 6'h09;         // Bits 13:8 of complement file
   localparam int COMPF_OPC_LO = 8;
   localparam int DEST_BIT = 7;
   localparam int FADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int FILE_DEPTH = 128;
   localparam int LATCH_HI = 4;                      // High latch bits 4:3 feed pc 12:11
   localparam int LATCH_LO = 3;
   localparam int LATCH_W = 5;

   // ****************************************************************
   // Register map, byte addresses on the bus
   // ****************************************************************
   localparam logic [7:0] ACC_OFF = 8'h00;
   localparam logic [7:0] STATUS_OFF = 8'h04;
   localparam logic [7:0] LATCH_OFF = 8'h08;
   localparam logic [7:0] PC_OFF = 8'h0C;
   localparam int ST_ZERO = 0;
   localparam int ST_PWRDN = 3;
   localparam int ST_TMOUT = 4;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [12:0] PC_RST = 13'h0000;
   localparam logic [4:0] LATCH_RST = 5'h00;
   localparam logic ZERO_RST = 1'b0;
   localparam logic TMOUT_RST = 1'b1;
   localparam logic PWRDN_RST = 1'b1;

   // ****************************************************************
   // Sequencer states, one-hot
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_EXEC = 3'h2,
      ST_CALL2 = 3'h4
   } ccx_state_e;

endpackage

// [ccx_file_mem.sv]
// Small file register store, read data registered
module ccx_file_mem (
   input wire logic mclk,
   input wire logic we,
   input wire logic [ccx_pkg::FADDR_W-1:0] waddr,
   input wire logic [ccx_pkg::DATA_W-1:0] wdata,
   input wire logic [ccx_pkg::FADDR_W-1:0] raddr,
   output logic [ccx_pkg::DATA_W-1:0] rdata
);

   logic [ccx_pkg::DATA_W-1:0] mem [ccx_pkg::FILE_DEPTH];

   // Contents are not reset; software must initialise them
   always_ff @(posedge mclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end

endmodule

// [ccx_core_sva.sv]
module ccx_core_sva (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [13:0] instr,
   input wire logic instr_valid,
   input wire logic instr_ready,
   input wire logic stack_push,
   input wire logic [12:0] stack_top,
   input wire logic [12:0] program_counter,
   input wire logic watchdog_clear,
   input wire logic prescaler_clear
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // Decode of the offered word, goto excluded from the plain class
   wire logic take = instr_valid && instr_ready;
   wire logic is_call = take && instr[13:11] == 3'h4;
   wire logic plain = take && instr[13:12] != 2'h2;
   sequence call_wait_s;
      !instr_ready ##1 !instr_ready ##1 instr_ready;
   endsequence
   sequence plain_done_s;
      !instr_ready ##1 (instr_ready && program_counter == $past(program_counter, 2) + 13'h1);
   endsequence
   call_push_a: assert property (is_call |=> stack_push
      && stack_top == $past(program_counter) + 13'h1)
      else $error("return address not pushed");
   push_once_a: assert property (stack_push |=> !stack_push)
      else $error("push longer than one cycle");
   call_target_a: assert property (is_call |=> ##1
      program_counter[10:0] == $past(instr[10:0], 2))
      else $error("call target wrong");
   call_len_a: assert property (is_call |=> call_wait_s)
      else $error("call length wrong");
   wdog_pulse_a: assert property ((take && instr == 14'h0064) |=> ##1 watchdog_clear)
      else $error("watchdog clear missing");
   wdog_pair_a: assert property (watchdog_clear == prescaler_clear)
      else $error("prescaler clear not paired");
   wdog_cause_a: assert property (watchdog_clear |->
      $past(take, 2) && $past(instr, 2) == 14'h0064)
      else $error("watchdog clear without cause");
   plain_cycle_a: assert property (plain |=> plain_done_s)
      else $error("single cycle timing wrong");
endmodule

bind ccx_core ccx_core_sva u_sva (.mclk(mclk), .rst(rst), .instr(instr),
   .instr_valid(instr_valid), .instr_ready(instr_ready), .stack_push(stack_push),
   .stack_top(stack_top), .program_counter(program_counter),
   .watchdog_clear(watchdog_clear), .prescaler_clear(prescaler_clear));

// [ccx_prog_mem.sv]
// Program memory: offers the word at the counter for a set number of takes
module ccx_prog_mem (
   input wire logic mclk,
   input wire logic rst,
   input wire logic instr_ready,
   input wire logic [12:0] program_counter,
   input wire logic start,
   input wire logic [3:0] count,
   output logic [13:0] instr,
   output logic instr_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [13:0] mem [256];
   logic [3:0] left;
   logic [3:0] next_left;
   // Count down one offer per take
   always_comb begin
      next_left = left;
      if (start) next_left = count;
      else if (instr_valid && instr_ready) next_left = left - 4'h1;
   end
   always_ff @(posedge mclk) begin
      left <= rst ? 4'h0 : next_left;
   end
   // Off-offer word is garbage so a stale read cannot look valid
   // Offer only while the core can take, so a word never changes under a raised valid
   assign instr_valid = (left != 4'h0) && instr_ready;
   assign instr = instr_valid ? mem[program_counter[7:0]] : ~{1'b0, program_counter};
endmodule

// [tb.sv]
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic we; logic [7:0] adr; logic [31:0] d;} ccx_row_s;
   logic mclk, rst, cyc, stb, we, start, instr_valid, instr_ready, stack_push, ack;
   logic watchdog_clear, prescaler_clear;
   logic [3:0] cnt;
   logic [7:0] adr;
   logic [13:0] instr;
   logic [12:0] stack_top, program_counter;
   logic [31:0] wd, rd, q;
   int err_total, check_count, cycles, wdog_n, push_n;
   ccx_row_s rows [15] = '{'{0, 8'h00, 32'h0}, '{0, 8'h04, 32'h18}, '{0, 8'h08, 32'h0},
      '{0, 8'h0C, 32'h0}, '{0, 8'h10, 32'h0}, '{1, 8'h00, 32'h5A}, '{0, 8'h00, 32'h5A},
      '{1, 8'h08, 32'h18}, '{0, 8'h08, 32'h18}, '{1, 8'h04, 32'h0}, '{0, 8'h04, 32'h0},
      '{1, 8'h0C, 32'h55}, '{0, 8'h0C, 32'h0}, '{1, 8'h10, 32'hFF}, '{0, 8'h10, 32'h0}};
   ccx_core DUT (.mclk(mclk), .rst(rst), .instr(instr), .instr_valid(instr_valid),
      .instr_ready(instr_ready), .stack_push(stack_push), .stack_top(stack_top),
      .program_counter(program_counter), .watchdog_clear(watchdog_clear),
      .prescaler_clear(prescaler_clear), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack));
   ccx_prog_mem pm (.mclk(mclk), .rst(rst), .instr_ready(instr_ready),
      .program_counter(program_counter), .start(start), .count(cnt), .instr(instr),
      .instr_valid(instr_valid));
   always #20 mclk = ~mclk;
   // Pulse counters and hang guard
   always @(posedge mclk) begin
      cycles++;
      if (!rst && watchdog_clear === 1'b1) wdog_n++;
      if (!rst && stack_push === 1'b1) push_n++;
      if (cycles == 3000) begin
         err_total++;
         conclude();
      end
   end
   // One classic cycle; held until ack is seen on a rising edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wd <= d;
      do @(posedge mclk); while (ack !== 1'b1);
      q = rd;
      cyc <= 0;
      stb <= 0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      wb(0, a, 32'h0);
      chk(q, exp);
   endtask
   // Let n words be taken; three edges cover the longest execute
   task automatic run(input logic [3:0] n);
      @(posedge mclk);
      start <= 1;
      cnt <= n;
      @(posedge mclk);
      start <= 0;
      do @(posedge mclk); while (pm.left !== 4'h0);
      repeat (3) @(posedge mclk);
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      {mclk, cyc, stb, we, start, cnt, adr, wd} = '0;
      rst = 1;
      pm.mem[0] = 14'h0064;
      pm.mem[1] = 14'h0985;
      pm.mem[2] = 14'h2020;
      pm.mem[32] = 14'h017F;
      pm.mem[33] = 14'h0905;
      pm.mem[34] = 14'h0906;
      DUT.u_file.mem[5] = 8'h13;
      DUT.u_file.mem[6] = 8'hFF;
      repeat (6) @(posedge mclk);
      rst <= 0;
      // Reset values, unmapped and read-only places
      foreach (rows[i]) begin
         if (rows[i].we) wb(1, rows[i].adr, rows[i].d);
         else rd_chk(rows[i].adr, rows[i].d);
      end
      $display("register rows done");
      run(1);
      rd_chk(8'h04, 32'h18);
      rd_chk(8'h00, 32'h5A);
      chk(wdog_n, 1);
      $display("watchdog clear done");
      run(1);
      rd_chk(8'h00, 32'h5A);
      rd_chk(8'h0C, 32'h2);
      rd_chk(8'h04, 32'h18);
      $display("complement done");
      run(2);
      rd_chk(8'h0C, 32'h1821);
      chk(stack_top, 32'h3);
      chk(push_n, 1);
      rd_chk(8'h00, 32'h0);
      rd_chk(8'h04, 32'h19);
      $display("call and clear done");
      // Read back the written file word, then a complement that gives zero
      run(1);
      rd_chk(8'h00, 32'h13);
      rd_chk(8'h04, 32'h18);
      run(1);
      rd_chk(8'h00, 32'h0);
      rd_chk(8'h04, 32'h19);
      rd_chk(8'h0C, 32'h1823);
      $display("complement readback done");
      // Second reset between runs, with the core idle
      @(posedge mclk);
      rst <= 1;
      repeat (2) @(posedge mclk);
      rst <= 0;
      rd_chk(8'h04, 32'h18);
      rd_chk(8'h0C, 32'h0);
      rd_chk(8'h08, 32'h0);
      $display("second reset done");
      conclude();
   end
endmodule
